// [inc/sxm_pkg.sv]
// package of constants and types for the serial expansion master
package sxm_pkg;
    // clock rates in kHz: system clock and the divided reference
    localparam int unsigned CLK_KHZ = 50000;
    localparam int unsigned REF_KHZ = 33000;
    localparam int unsigned ACC_W   = 17;
    // serial word and edge counting
    localparam int unsigned WORD_W    = 8;
    localparam logic [3:0]  EDGE_LAST = 4'hf;
    localparam logic [3:0]  HALF_BASE = 4'h2;
    localparam logic [3:0]  CNT_ONE   = 4'h1;
    // device numbers that own a select
    localparam logic [2:0]  DEV_ZERO = 3'h0;
    localparam logic [2:0]  DEV_ONE  = 3'h1;
    localparam logic [2:0]  DEV_ADC  = 3'h5;
    // transfer sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_LEAD  = 5'b00010,
        ST_SHIFT = 5'b00100,
        ST_TAIL  = 5'b01000,
        ST_PUSH  = 5'b10000
    } sxm_state_e;
endpackage : sxm_pkg

// [inc/sxm_strm_if.sv]
// valid/ready word stream between the master and its buffer
interface sxm_strm_if #(parameter int unsigned W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sxm_strm_if

// [design/sxm_fifo2.sv]
// two-entry flip-flop buffer with valid and ready on both sides
module sxm_fifo2
    import sxm_pkg::*;
#(
    parameter int unsigned W     = WORD_W,
    parameter int unsigned DEPTH = 2
) (
    input  wire logic   clk,
    input  wire logic   rst,
    sxm_strm_if.snk     in_s,
    sxm_strm_if.src     out_s
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;

    // pointer step with wrap at the depth
    function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : ptr_step

    // handshake decode
    wire do_push = in_s.valid && in_s.ready;
    wire do_pop  = out_s.valid && out_s.ready;
    assign in_s.ready  = (count != FULL_CNT);
    assign out_s.valid = (count != '0);
    assign out_s.data  = mem[rd_ptr];

    // storage write
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr] <= in_s.data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= ptr_step(wr_ptr);
            end
            if (do_pop) begin
                rd_ptr <= ptr_step(rd_ptr);
            end
            count <= count + CW'(do_push) - CW'(do_pop);
        end
    end

    // occupancy never passes the depth
    fifo_bound_a: assert property (@(posedge clk) disable iff (rst)
        count <= FULL_CNT)
        else $error("buffer occupancy above depth");
endmodule : sxm_fifo2

// [design/sxm_master.sv]
// spi master for the serial expansion link with converter select
module sxm_master
    import sxm_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              cfg_cpol,
    input  wire logic              cfg_cpha,
    input  wire logic [1:0]        cfg_div,
    input  wire logic [2:0]        cfg_dev,
    input  wire logic [WORD_W-1:0] tx_data,
    input  wire logic              tx_valid,
    output logic                   tx_ready,
    output logic [WORD_W-1:0]      rx_data,
    output logic                   rx_valid,
    input  wire logic              rx_ready,
    output logic                   busy,
    output logic                   dev_bad,
    output logic                   sclk,
    output logic                   mosi,
    input  wire logic              miso,
    output logic                   select_line_zero_n,
    output logic                   select_line_one_n,
    output logic                   adc_sel_n
);
    sxm_state_e state;
    sxm_state_e next_state;

    logic [ACC_W-1:0]  ref_acc;
    logic              ref_tick;
    logic [3:0]        half_cnt;
    logic [3:0]        edge_idx;
    logic [1:0]        div_lat;
    logic              cpol_lat;
    logic              cpha_lat;
    logic [2:0]        dev_lat;
    logic [WORD_W-1:0] tx_sh;
    logic [WORD_W-1:0] rx_sh;
    logic              miso_s1;
    logic              miso_s2;
    logic              miso_s3;
    logic              miso_q;
    logic [1:0]        samp_dly;

    // last ref tick index of one half serial clock period
    function automatic logic [3:0] half_last(input logic [1:0] div);
        return (HALF_BASE << div) - CNT_ONE;
    endfunction : half_last

    // device number decode
    function automatic logic dev_known(input logic [2:0] dev);
        return (dev == DEV_ZERO) || (dev == DEV_ONE) || (dev == DEV_ADC);
    endfunction : dev_known

    // received words pass through the two-entry buffer
    sxm_strm_if #(.W(WORD_W)) rx_in ();
    sxm_strm_if #(.W(WORD_W)) rx_out ();

    sxm_fifo2 #(
        .W     (WORD_W),
        .DEPTH (2)
    ) u_rx_buf (
        .clk   (clk),
        .rst   (rst),
        .in_s  (rx_in.snk),
        .out_s (rx_out.src)
    );

    // stream wiring towards the user side
    assign rx_in.valid  = (state == ST_PUSH);
    assign rx_in.data   = rx_sh;
    assign rx_data      = rx_out.data;
    assign rx_valid     = rx_out.valid;
    assign rx_out.ready = rx_ready;

    // reference ticks at 33 MHz on average from the 50 MHz clock
    wire [ACC_W-1:0] acc_sum  = ref_acc + ACC_W'(REF_KHZ);
    wire             acc_wrap = (acc_sum >= ACC_W'(CLK_KHZ));

    // accumulator starts one step in so two tickless cycles never follow each other
    always_ff @(posedge clk) begin
        if (rst) begin
            ref_acc  <= ACC_W'(REF_KHZ);
            ref_tick <= 1'b0;
        end else begin
            ref_acc  <= acc_wrap ? acc_sum - ACC_W'(CLK_KHZ) : acc_sum;
            ref_tick <= acc_wrap;
        end
    end

    // half period timing, edge type and start decode
    wire half_tick  = ref_tick && (half_cnt == half_last(div_lat));
    wire last_edge  = (edge_idx == EDGE_LAST);
    wire samp_edge  = (edge_idx[0] == cpha_lat);
    // a pending idle level change reaches the pin before any select falls
    wire start      = (state == ST_IDLE) && tx_valid && dev_known(cfg_dev)
                      && rx_in.ready && (sclk == cfg_cpol);
    assign tx_ready = start;
    assign busy     = (state != ST_IDLE);
    assign dev_bad  = !dev_known(cfg_dev);

    // next state of the transfer sequencer
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = ST_LEAD;
                end
            end
            ST_LEAD: begin
                if (half_tick) begin
                    next_state = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (half_tick && last_edge) begin
                    next_state = ST_TAIL;
                end
            end
            ST_TAIL: begin
                if (half_tick) begin
                    next_state = ST_PUSH;
                end
            end
            ST_PUSH: begin
                if (rx_in.ready) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ref tick counter inside one half period
    always_ff @(posedge clk) begin
        if (rst || start || half_tick) begin
            half_cnt <= '0;
        end else if (ref_tick) begin
            half_cnt <= half_cnt + CNT_ONE;
        end
    end

    // settings held for the whole transfer
    always_ff @(posedge clk) begin
        if (rst) begin
            div_lat  <= '0;
            cpol_lat <= 1'b0;
            cpha_lat <= 1'b0;
            dev_lat  <= DEV_ZERO;
        end else if (start) begin
            div_lat  <= cfg_div;
            cpol_lat <= cfg_cpol;
            cpha_lat <= cfg_cpha;
            dev_lat  <= cfg_dev;
        end
    end

    // serial clock: idle level when quiet, toggles each half period of the shift state
    always_ff @(posedge clk) begin
        if (rst) begin
            sclk <= 1'b0;
        end else if (state == ST_IDLE) begin
            sclk <= cfg_cpol;
        end else if (state == ST_SHIFT && half_tick) begin
            sclk <= ~sclk;
        end
    end

    // edge counter across the sixteen clock edges of a word
    always_ff @(posedge clk) begin
        if (rst || start) begin
            edge_idx <= '0;
        end else if (state == ST_SHIFT && half_tick) begin
            edge_idx <= edge_idx + CNT_ONE;
        end
    end

    // transmit shifter; phase 0 presents the first bit before any edge
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_sh <= '0;
            mosi  <= 1'b0;
        end else if (start) begin
            tx_sh <= cfg_cpha ? tx_data : {tx_data[WORD_W-2:0], 1'b0};
            mosi  <= cfg_cpha ? mosi : tx_data[WORD_W-1];
        end else if (state == ST_SHIFT && half_tick && !samp_edge) begin
            tx_sh <= {tx_sh[WORD_W-2:0], 1'b0};
            mosi  <= tx_sh[WORD_W-1];
        end
    end

    // serial input passes three flops; a change counts when two agree
    always_ff @(posedge clk) begin
        if (rst) begin
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
            miso_s3 <= 1'b0;
            miso_q  <= 1'b0;
        end else begin
            miso_s1 <= miso;
            miso_s2 <= miso_s1;
            miso_s3 <= miso_s2;
            if (miso_s2 == miso_s3) begin
                miso_q <= miso_s3;
            end
        end
    end

    // filtered input: agreeing second and third stages count at once
    wire miso_f   = (miso_s2 == miso_s3) ? miso_s3 : miso_q;
    wire samp_now = (state == ST_SHIFT) && half_tick && samp_edge;

    // receive shifter takes its bit two cycles after the sampling edge:
    // that covers the synchroniser delay while the slave still holds the bit
    always_ff @(posedge clk) begin
        if (rst) begin
            samp_dly <= '0;
            rx_sh    <= '0;
        end else begin
            samp_dly <= {samp_dly[0], samp_now};
            if (samp_dly[1]) begin
                rx_sh <= {rx_sh[WORD_W-2:0], miso_f};
            end
        end
    end

    // selects: one asserted from start until the tail half period ends
    wire sel_clear = (state == ST_TAIL) && half_tick;
    always_ff @(posedge clk) begin
        if (rst || sel_clear) begin
            select_line_zero_n <= 1'b1;
            select_line_one_n  <= 1'b1;
            adc_sel_n          <= 1'b1;
        end else if (start) begin
            select_line_zero_n <= !(cfg_dev == DEV_ZERO);
            select_line_one_n  <= !(cfg_dev == DEV_ONE);
            adc_sel_n          <= !(cfg_dev == DEV_ADC);
        end
    end

    // assertion helpers
    wire [2:0] sel_act = {!select_line_zero_n, !select_line_one_n, !adc_sel_n};

    selects_idle_a: assert property (@(posedge clk) disable iff (rst)
        (state == ST_IDLE) |-> (sel_act == 3'h0))
        else $error("select low while idle");

    one_select_a: assert property (@(posedge clk) disable iff (rst)
        (state == ST_SHIFT || state == ST_TAIL) |-> $onehot(sel_act))
        else $error("not exactly one select during transfer");

    clk_idle_a: assert property (@(posedge clk) disable iff (rst)
        (state == ST_IDLE && $past(state == ST_IDLE)) |-> sclk == $past(cfg_cpol))
        else $error("serial clock not at idle level");

    clk_lead_a: assert property (@(posedge clk) disable iff (rst)
        (state == ST_LEAD || state == ST_TAIL) |-> sclk == cpol_lat)
        else $error("serial clock off idle outside shifting");

    clk_step_a: assert property (@(posedge clk) disable iff (rst)
        (state == ST_SHIFT && $changed(sclk)) |-> $past(half_tick))
        else $error("serial clock moved without half period");

    ref_rate_a: assert property (@(posedge clk) disable iff (rst)
        !ref_tick |=> ref_tick)
        else $error("reference tick missing two cycles running");

    start_only_a: assert property (@(posedge clk) disable iff (rst)
        $fell(sel_act == 3'h0) |-> $past(tx_ready) && $past(tx_valid))
        else $error("select asserted without a start");

    adc_select_a: assert property (@(posedge clk) disable iff (rst)
        (!adc_sel_n) |-> (dev_lat == DEV_ADC))
        else $error("converter select for wrong device");

    push_word_a: assert property (@(posedge clk) disable iff (rst)
        (state == ST_TAIL && half_tick) |=> rx_in.valid && samp_dly == '0)
        else $error("received word offered before its last bit");

    sclk_quiet_a: assert property (@(posedge clk) disable iff (rst)
        $fell(sel_act == 3'h0) |-> $stable(sclk))
        else $error("serial clock moved as select asserted");

    edge_end_a: assert property (@(posedge clk) disable iff (rst)
        $rose(state == ST_TAIL) |-> $past(last_edge) && sel_act != 3'h0)
        else $error("select dropped before last edge");
endmodule : sxm_master

// [testbench/sxm_slave.sv]
// behavioural slave device on the serial expansion link
module sxm_slave (
    input  wire logic       sclk,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    input  wire logic       cpha,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic [7:0]      rx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    int         nb;
    int         ne;
    logic [7:0] sh;
    // clock is only listened to, never driven from this side
    initial begin
        miso = 1'b0;
        rx_byte = 8'h00;
        nb = 0;
        ne = 0;
        sh = 8'h00;
    end
    // load the reply on select, leave junk on the unpulled line when released
    always @(sel_n) begin
        if (sel_n === 1'b0) begin
            sh = tx_byte;
            nb = 0;
            ne = 0;
            if (!cpha) begin
                miso = sh[7];
                nb = 1;
            end
        end else begin
            miso = ~miso;
        end
    end
    // sample on edges of phase parity, shift out msb first on the others
    always @(sclk) begin
        if (sel_n === 1'b0) begin
            if (ne % 2 == int'(cpha)) begin
                rx_byte = {rx_byte[6:0], mosi};
            end else if (nb < 8) begin
                miso = sh[7-nb];
                nb++;
            end
            ne++;
        end
    end
endmodule : sxm_slave

// [testbench/tb.sv]
// self-checking bench for the serial expansion master
module tb
    import sxm_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk, rst, cfg_cpol, cfg_cpha, tx_valid, miso;
    logic              rx_ready = 1'b0;
    logic [1:0]        cfg_div;
    logic [2:0]        cfg_dev;
    logic [WORD_W-1:0] tx_data, rx_data, s_tx, rx0, rx1, rx5;
    logic              tx_ready, rx_valid, busy, dev_bad, sclk, mosi;
    logic              sel0_n, sel1_n, adc_n, m0, m1, m5;
    int                n_fail, n_compared, rx_en;
    logic [WORD_W-1:0] exp_q[$];
    logic [2:0]        devs[3] = '{DEV_ZERO, DEV_ONE, DEV_ADC};
    logic [2:0]        bad[5] = '{3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    sxm_master dut_u (.clk(clk), .rst(rst), .cfg_cpol(cfg_cpol), .cfg_cpha(cfg_cpha),
        .cfg_div(cfg_div), .cfg_dev(cfg_dev), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .busy(busy), .dev_bad(dev_bad), .sclk(sclk), .mosi(mosi), .miso(miso),
        .select_line_zero_n(sel0_n), .select_line_one_n(sel1_n), .adc_sel_n(adc_n));
    sxm_slave s0_u (.sclk(sclk), .mosi(mosi), .sel_n(sel0_n), .cpha(cfg_cpha),
        .tx_byte(s_tx), .miso(m0), .rx_byte(rx0));
    sxm_slave s1_u (.sclk(sclk), .mosi(mosi), .sel_n(sel1_n), .cpha(cfg_cpha),
        .tx_byte(s_tx), .miso(m1), .rx_byte(rx1));
    sxm_slave s5_u (.sclk(sclk), .mosi(mosi), .sel_n(adc_n), .cpha(cfg_cpha),
        .tx_byte(s_tx), .miso(m5), .rx_byte(rx5));
    // shared data-in line: the selected slave, else junk
    assign miso = !sel1_n ? m1 : (!adc_n ? m5 : m0);
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk
    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results
    // receiver side: pop the model queue at every accepted word
    always @(negedge clk) begin
        rx_ready = rx_en[0];
        if (rx_valid === 1'b1 && rx_en != 0) begin
            if (exp_q.size() == 0)
                chk("rx_extra", 1, 0);
            else
                chk("rx_data", rx_data, exp_q.pop_front());
        end
    end
    // one whole transfer with timing and select checks
    task automatic xfer(input logic [2:0] dev, input logic [1:0] div, input logic [1:0] md);
        int         low, tog, k, ec;
        logic       last;
        logic [2:0] used;
        logic [7:0] d;
        d = 8'($urandom);
        @(negedge clk);
        cfg_dev = dev;
        cfg_div = div;
        cfg_cpol = md[1];
        cfg_cpha = md[0];
        tx_data = d;
        s_tx = 8'($urandom);
        tx_valid = 1'b1;
        // tx_ready is combinational: look at it just before the edge that takes it
        k = 0;
        do begin
            @(posedge clk);
            k++;
            if (k > 3000) begin
                chk("ready_wait", 0, 1);
                results();
            end
        end while (tx_ready !== 1'b1);
        exp_q.push_back(s_tx);
        @(negedge clk);
        tx_valid = 1'b0;
        chk("busy", busy, 1);
        low = 0;
        tog = 0;
        used = 3'h0;
        last = sclk;
        for (k = 0; busy === 1'b1; k++) begin
            if (k > 3000) begin
                chk("busy_wait", 0, 1);
                results();
            end
            if (sclk !== last) tog++;
            last = sclk;
            used = used | {~adc_n, ~sel1_n, ~sel0_n};
            if (!sel0_n || !sel1_n || !adc_n) low++;
            @(negedge clk);
        end
        ec = (450 * (4 << div) + 16) / 33;
        chk("sclk_edges", tog, 16);
        chk("sel_used", used, dev == DEV_ADC ? 4 : (dev == DEV_ONE ? 2 : 1));
        chk("sel_time", int'(low >= ec - 6 && low <= ec + 6), 1);
        chk("sclk_idle", sclk, md[1]);
        chk("sels_idle", {sel0_n, sel1_n, adc_n}, 3'h7);
        chk("slave_rx", dev == DEV_ADC ? rx5 : (dev == DEV_ONE ? rx1 : rx0), d);
    endtask : xfer
    // main sequence
    initial begin
        void'($urandom(38));
        {rst, tx_valid, cfg_cpol, cfg_cpha, cfg_div, cfg_dev} = 9'h100;
        tx_data = 8'h00;
        s_tx = 8'h00;
        rx_en = 1;
        n_fail = 0;
        n_compared = 0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk("reset_out", {sel0_n, sel1_n, adc_n, busy, rx_valid}, 5'h1c);
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            for (int v = 0; v < 4; v++) begin
                xfer(devs[(m * 4 + v) % 3], 2'(v), 2'(m));
            end
        end
        $display("test modes and dividers done");
        foreach (bad[i]) begin
            @(negedge clk);
            cfg_dev = bad[i];
            tx_valid = 1'b1;
            repeat (20) begin
                @(negedge clk);
                chk("ready_bad_dev", tx_ready, 0);
            end
            chk("dev_bad", dev_bad, 1);
            chk("no_start", {busy, sel0_n, sel1_n, adc_n}, 4'h7);
        end
        tx_valid = 1'b0;
        $display("test refused devices done");
        @(posedge clk);
        rx_en = 0;
        xfer(DEV_ONE, 2'h0, 2'h1);
        xfer(DEV_ADC, 2'h0, 2'h2);
        @(negedge clk);
        cfg_dev = DEV_ZERO;
        tx_valid = 1'b1;
        repeat (30) begin
            @(negedge clk);
            chk("ready_full", {tx_ready, rx_valid}, 2'h1);
        end
        tx_valid = 1'b0;
        @(posedge clk);
        rx_en = 1;
        repeat (6) @(negedge clk);
        chk("drained", {exp_q.size() == 0, rx_valid}, 2'h2);
        xfer(DEV_ZERO, 2'h3, 2'h3);
        repeat (6) @(negedge clk);
        chk("rx_left", exp_q.size(), 0);
        $display("test buffer stall done");
        results();
    end
endmodule : tb
